// >>> hw/dagu_pkg.sv
// Package for the DSP address generation unit: widths, encodings, structs.
// Assumes a single core clock and synchronous active-high reset.
package dagu_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned NUM_PTR  = 4;
  localparam int unsigned PSEL_W   = 2;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ONE      = 16'h0001;
  // Modifier value of all ones selects linear arithmetic
  localparam logic [15:0] MOD_LINEAR = 16'hFFFF;
  localparam logic [15:0] MOD_RST    = 16'hFFFF;
  localparam logic [15:0] PC_STEP    = 16'h0001;

  // ****************************************************************
  // Post-update kinds
  // ****************************************************************
  typedef enum logic [1:0] {
    DAGU_UPD_NONE = 2'h0,
    DAGU_UPD_INC  = 2'h1,
    DAGU_UPD_DEC  = 2'h2,
    DAGU_UPD_OFS  = 2'h3
  } dagu_upd_t;

  // Instruction move type
  typedef enum logic [1:0] {
    DAGU_MV_NONE   = 2'h0,
    DAGU_MV_SINGLE = 2'h1,
    DAGU_MV_DUAL   = 2'h3
  } dagu_mv_t;

  // One address request for one arithmetic unit
  typedef struct packed {
    logic [1:0] ptr;
    dagu_upd_t  upd;
    logic       wr;
  } dagu_req_t;

  // One data memory access
  typedef struct packed {
    logic        en;
    logic        wr;
    logic [15:0] addr;
  } dagu_acc_t;

endpackage

// >>> hw/dagu_arith.sv
// One address arithmetic unit: linear or modulo post-update of a pointer.
// Assumes modulo buffers aligned to the smallest power of two not below their size.
`timescale 1ns/1ps
`default_nettype none
module dagu_arith
  import dagu_pkg::*;
(
  // Operands
  input  wire logic [15:0] ptr_val,
  input  wire logic [15:0] ofs_val,
  input  wire logic [15:0] mod_val,
  input  wire dagu_upd_t   upd,
  // Result
  output logic      [15:0] ptr_new
);

  // ****************************************************************
  // Step and linear sum
  // ****************************************************************
  logic [15:0] step;
  logic [15:0] lin_sum;
  logic [15:0] mask;
  logic [15:0] base;
  logic [15:0] last;
  logic [16:0] lin_ext;
  logic [16:0] over;
  logic [16:0] under;
  logic [16:0] size;
  logic        is_lin;
  logic        past_top;
  logic        below_base;

  function automatic logic [15:0] fill_mask(input logic [15:0] v);
    logic [15:0] m;
    m = v;
    m = m | (m >> 1);
    m = m | (m >> 2);
    m = m | (m >> 4);
    m = m | (m >> 8);
    return m;
  endfunction

  assign step = (upd == DAGU_UPD_INC) ? ONE :
                (upd == DAGU_UPD_DEC) ? (~ONE + ONE) :
                (upd == DAGU_UPD_OFS) ? ofs_val : '0;
  assign lin_sum = ptr_val + step;
  assign is_lin  = (mod_val == MOD_LINEAR) || (upd == DAGU_UPD_NONE);
  // Buffer spans base .. base+mod_val, base aligned on mask
  assign mask  = fill_mask(mod_val);
  assign base  = ptr_val & ~mask;
  assign last  = base + mod_val;
  assign size  = {1'b0, mod_val} + {1'b0, ONE};
  assign lin_ext = {1'b0, lin_sum};
  // Signed step decides direction of possible overshoot
  assign over  = lin_ext - size;
  assign under = lin_ext + size;

  // Forward step past the top, or backward step below the base
  assign past_top   = !step[15] &&
                      ({1'b0, ptr_val} + {1'b0, step} > {1'b0, last});
  assign below_base = step[15] &&
                      ({1'b0, ptr_val} < {1'b0, base} + {1'b0, ~step + ONE});

  always_comb begin
    ptr_new = lin_sum;
    if (!is_lin && past_top) begin
      ptr_new = over[15:0];
    end else if (!is_lin && below_base) begin
      ptr_new = under[15:0];
    end
  end

endmodule
`default_nettype wire

// >>> hw/dagu_top.sv
// Address generation unit of a 16-bit DSP core, with program fetch address.
// Assumes memories accept two data accesses and one fetch each cycle.
//
// Notes on behaviour
// - Two arithmetic units and own pointers give two addresses per cycle.
// - Linear mode updates pointers with plain 16-bit two's complement sums.
// - Modulo mode wraps results beyond the buffer top back inside.
// - Modulo mode wraps results below the buffer base back inside.
// - Wrap stays correct when the step overshoots a boundary by no more than the buffer size.
// - Fetch address is produced in the same cycle as data addresses.
// - Single parallel move: one read or write, one pointer update.
// - Dual parallel read: two reads in one cycle; two address updates unless both units name one pointer.
// - Post-increment, post-decrement or post-offset after current address.
// - Three memory accesses sustained per cycle.
// - Moves work inside loops, repeats and outside, unrestricted.
`timescale 1ns/1ps
`default_nettype none
module dagu_top
  import dagu_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // Instruction decode
  input  wire dagu_mv_t    MOVE_TYPE,
  input  wire dagu_req_t   REQ_A,
  input  wire dagu_req_t   REQ_B,
  input  wire logic        FETCH_EN,
  // Pointer, offset and modifier loads
  input  wire logic        PTR_LOAD,
  input  wire logic [1:0]  PTR_SEL,
  input  wire logic [15:0] PTR_DATA,
  input  wire logic        OFS_LOAD,
  input  wire logic [15:0] OFS_DATA,
  input  wire logic        MOD_LOAD,
  input  wire logic [1:0]  MOD_SEL,
  input  wire logic [15:0] MOD_DATA,
  // Jump
  input  wire logic        PC_LOAD,
  input  wire logic [15:0] PC_DATA,
  // Memory side
  output dagu_acc_t        DATA_A,
  output dagu_acc_t        DATA_B,
  output logic [15:0]      PROG_ADDR,
  output logic             PROG_EN
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] ptr_reg [NUM_PTR];
  logic [15:0] mod_reg [NUM_PTR];
  logic [15:0] ofs_reg;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  dagu_acc_t   acc_a_reg;
  dagu_acc_t   acc_b_reg;
  logic        fetch_reg;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic        use_a;
  logic        use_b;
  logic [15:0] new_a;
  logic [15:0] new_b;
  logic        clash;

  // Moves are taken on any cycle, inside a loop or outside one
  assign use_a = (MOVE_TYPE != DAGU_MV_NONE);
  assign use_b = (MOVE_TYPE == DAGU_MV_DUAL);
  // Same pointer on both units: unit B update wins
  assign clash = use_b && (REQ_A.ptr == REQ_B.ptr);
  assign pc_next = PC_LOAD ? PC_DATA : pc_reg + PC_STEP;

  // True when a two-bit select code names pointer idx
  function automatic logic names_ptr(input logic [1:0]  sel,
                                     input int unsigned idx);
    return sel == PSEL_W'(idx);
  endfunction

  // ****************************************************************
  // Two arithmetic units
  // ****************************************************************
  dagu_arith u_arith_a (
    .ptr_val (ptr_reg[REQ_A.ptr]),
    .ofs_val (ofs_reg),
    .mod_val (mod_reg[REQ_A.ptr]),
    .upd     (REQ_A.upd),
    .ptr_new (new_a)
  );

  dagu_arith u_arith_b (
    .ptr_val (ptr_reg[REQ_B.ptr]),
    .ofs_val (ofs_reg),
    .mod_val (mod_reg[REQ_B.ptr]),
    .upd     (REQ_B.upd),
    .ptr_new (new_b)
  );

  // ****************************************************************
  // Per-pointer next values
  // ****************************************************************
  // Priority on one pointer: load, then unit B, then unit A, else hold
  logic [15:0] ptr_next [NUM_PTR];
  logic [15:0] mod_next [NUM_PTR];
  logic [15:0] ofs_next;

  for (genvar g = 0; g < NUM_PTR; g++) begin : g_next
    logic hit_a;
    logic hit_b;
    logic hit_load;
    logic hit_mod;

    assign hit_a    = use_a && !clash && names_ptr(REQ_A.ptr, g);
    assign hit_b    = use_b && names_ptr(REQ_B.ptr, g);
    assign hit_load = PTR_LOAD && names_ptr(PTR_SEL, g);
    assign hit_mod  = MOD_LOAD && names_ptr(MOD_SEL, g);
    // A load on the same edge as an update overrides the update
    assign ptr_next[g] = hit_load ? PTR_DATA :
                         hit_b    ? new_b    :
                         hit_a    ? new_a    :
                         ptr_reg[g];
    assign mod_next[g] = hit_mod ? MOD_DATA : mod_reg[g];
  end

  // Offset register is shared by every pointer
  assign ofs_next = OFS_LOAD ? OFS_DATA : ofs_reg;

  // ****************************************************************
  // Pointer, modifier and offset registers
  // ****************************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_reg[i] <= ADDR_RST;
      end
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        mod_reg[i] <= MOD_RST;
      end
    end else begin
      mod_reg <= mod_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ofs_reg <= ADDR_RST;
    end else begin
      ofs_reg <= ofs_next;
    end
  end

  // ****************************************************************
  // Data access words
  // ****************************************************************
  // The access carries the pointer before its update: post-update
  dagu_acc_t   acc_a_next;
  dagu_acc_t   acc_b_next;
  logic [15:0] addr_a_cur;
  logic [15:0] addr_b_cur;

  assign addr_a_cur = ptr_reg[REQ_A.ptr];
  assign addr_b_cur = ptr_reg[REQ_B.ptr];
  // Only a single move may write; a dual move reads on both units
  assign acc_a_next = '{en: use_a, wr: REQ_A.wr & ~use_b,
                        addr: addr_a_cur};
  assign acc_b_next = '{en: use_b, wr: 1'b0,
                        addr: addr_b_cur};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_a_reg <= '0;
      acc_b_reg <= '0;
    end else begin
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
    end
  end

  // ****************************************************************
  // Program fetch address, in the same cycle as the data accesses
  // ****************************************************************
  // Fetch and jump both move the counter; without either it holds
  logic pc_move;

  assign pc_move = FETCH_EN || PC_LOAD;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pc_reg <= ADDR_RST;
    end else if (pc_move) begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= FETCH_EN;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign DATA_A    = acc_a_reg;
  assign DATA_B    = acc_b_reg;
  assign PROG_ADDR = pc_reg;
  assign PROG_EN   = fetch_reg;

endmodule
`default_nettype wire

// >>> tb/dagu_mem_model.sv
// Memory-side model: sinks the data and fetch accesses of each cycle.
// Assumes accesses are registered on the rising core clock edge.
`timescale 1ns/1ps
`default_nettype none
module dagu_mem_model
  import dagu_pkg::*;
(
  // Core side
  input  wire logic      clk,
  input  wire dagu_acc_t acc_a,
  input  wire dagu_acc_t acc_b,
  input  wire logic      fetch,
  // Cycles that carried three accesses
  output logic [15:0]    triples
);
  logic [15:0] count = 16'h0000;
  assign triples = count;
  // Sampled off the launch edge, so the accesses have settled
  always @(negedge clk) begin
    if (acc_a.en && acc_b.en && fetch) begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> tb/dagu_top_checker.sv
// Port checker of the address generation unit.
// Assumes it is bound to dagu_top.
`timescale 1ns/1ps
`default_nettype none
module dagu_top_checker
  import dagu_pkg::*;
(
  // Clock, reset and decode
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire dagu_mv_t    MOVE_TYPE,
  input wire dagu_req_t   REQ_A,
  input wire logic        FETCH_EN,
  input wire logic        PTR_LOAD,
  input wire logic        PC_LOAD,
  input wire logic [15:0] PC_DATA,
  // Memory side
  input wire dagu_acc_t   DATA_A,
  input wire dagu_acc_t   DATA_B,
  input wire logic [15:0] PROG_ADDR,
  input wire logic        PROG_EN
);
  // ****************************
  // Port relations
  // ****************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_dual_two_reads: assert property (
    MOVE_TYPE == DAGU_MV_DUAL |=> DATA_A.en && DATA_B.en && !DATA_A.wr)
    else $error("dual read");
  a_single_one_acc: assert property (
    MOVE_TYPE == DAGU_MV_SINGLE |=> DATA_A.en && !DATA_B.en)
    else $error("single move");
  a_idle_no_acc: assert property (
    MOVE_TYPE == DAGU_MV_NONE |=> !DATA_A.en && !DATA_B.en)
    else $error("idle access");
  a_single_wr_dir: assert property (
    MOVE_TYPE == DAGU_MV_SINGLE |=> DATA_A.wr == $past(REQ_A.wr))
    else $error("write direction");
  a_fetch_step: assert property (
    FETCH_EN && !PC_LOAD |=> PROG_EN && PROG_ADDR == $past(PROG_ADDR) + ONE)
    else $error("fetch step");
  a_jump_target: assert property (
    PC_LOAD |=> PROG_ADDR == $past(PC_DATA))
    else $error("jump target");
  a_fetch_idle: assert property (
    !FETCH_EN && !PC_LOAD |=> !PROG_EN && $stable(PROG_ADDR))
    else $error("fetch idle");
  a_hold_no_update: assert property (
    MOVE_TYPE == DAGU_MV_SINGLE && REQ_A.upd == DAGU_UPD_NONE && !PTR_LOAD
    ##1 MOVE_TYPE == DAGU_MV_SINGLE && REQ_A.ptr == $past(REQ_A.ptr)
    |=> DATA_A.addr == $past(DATA_A.addr))
    else $error("pointer moved");
  c_dual_fetch: cover property (MOVE_TYPE == DAGU_MV_DUAL && FETCH_EN);
  c_single_wr: cover property (MOVE_TYPE == DAGU_MV_SINGLE && REQ_A.wr);
  c_jump: cover property (PC_LOAD);
endmodule
bind dagu_top dagu_top_checker i_chk (.REF_CLK, .RST, .MOVE_TYPE, .REQ_A,
  .FETCH_EN, .PTR_LOAD, .PC_LOAD, .PC_DATA, .DATA_A, .DATA_B, .PROG_ADDR,
  .PROG_EN);
`default_nettype wire

// >>> tb/test_dsp_address_generation_unit.sv
// Random bench of the address unit against an integer model.
// Assumes dagu_pkg, dagu_mem_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_dsp_address_generation_unit;
  import dagu_pkg::*;
  logic        REF_CLK = 1'b0, RST = 1'b1;
  dagu_mv_t    mt = DAGU_MV_NONE;
  dagu_req_t   ra = '0, rb = '0;
  logic        fe = 1'b0, pl = 1'b0, ol = 1'b0, jl = 1'b0, pe;
  logic [1:0]  ps = 2'h0;
  logic [15:0] pd = 16'h0000, od = 16'h0000, md = 16'h0000, jd = 16'h0000;
  logic [15:0] pa, trip, pc = 16'h0000;
  dagu_acc_t   da, db, ea, eb;
  int          fails = 0, checks = 0, r, k, a, b;
  int          ptr [4] = '{32'hFFFE, 32'h25, 32'h42, 32'h3E};
  int          mv [4] = '{32'hFFFF, 32'h9, 32'h4, 32'hE};
  always #5 REF_CLK = ~REF_CLK;
  dagu_top i_dut (.REF_CLK, .RST, .MOVE_TYPE(mt), .REQ_A(ra), .REQ_B(rb),
    .FETCH_EN(fe), .PTR_LOAD(pl), .PTR_SEL(ps), .PTR_DATA(pd), .OFS_LOAD(ol),
    .OFS_DATA(od), .MOD_LOAD(pl), .MOD_SEL(ps), .MOD_DATA(md), .PC_LOAD(jl),
    .PC_DATA(jd), .DATA_A(da), .DATA_B(db), .PROG_ADDR(pa), .PROG_EN(pe));
  dagu_mem_model i_mem (.clk(REF_CLK), .acc_a(da), .acc_b(db), .fetch(pe),
    .triples(trip));
  task automatic chk(input string n, input logic [17:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Post-update of one pointer, linear or circular
  function automatic int upd(int p, int u, int m);
    int s, mk;
    s = u == 1 ? 1 : u == 2 ? -1 : u == 3 ? int'($signed(od)) : 0;
    if (m == 32'hFFFF) return (p + s) & 32'hFFFF;
    mk = 1;
    while (mk < m) mk = mk * 2 + 1;
    s = p + s - (p & ~mk);
    if (s > m) s -= m + 1;
    if (s < 0) s += m + 1;
    return (p & ~mk) + s;
  endfunction
  initial begin
    void'($urandom(32'h367b));
    repeat (10) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST = 1'b0;
    chk("reset", {da.en, db.en, pa}, 18'h0);
    od = 16'h0003;
    ol = 1'b1;
    pl = 1'b1;
    for (k = 0; k < 4; k++) begin
      ps = k[1:0];
      pd = ptr[k][15:0];
      md = mv[k][15:0];
      @(negedge REF_CLK);
    end
    pl = 1'b0;
    for (k = 0; k < 2000; k++) begin
      r = k == 1000 ? 0 : $urandom % 3;
      ol = k == 1000;
      od = k == 1000 ? 16'hFFFD : od;
      a = $urandom % 4;
      b = (a + $urandom % 4) % 4;
      mt = r == 0 ? DAGU_MV_NONE : r == 1 ? DAGU_MV_SINGLE : DAGU_MV_DUAL;
      ra = '{a[1:0], dagu_upd_t'($urandom % 4), r == 1 && $urandom % 2};
      rb = '{b[1:0], dagu_upd_t'($urandom % 4), 1'b0};
      jl = $urandom % 16 == 0;
      jd = 16'($urandom);
      fe = !jl && $urandom % 2;
      ea = '{r != 0, ra.wr, ptr[a][15:0]};
      eb = '{r == 2, 1'b0, ptr[b][15:0]};
      if (r == 0) ea = '0;
      if (r != 2) eb = '0;
      // Same pointer on both units: unit B's update is the one kept
      if (r == 1 || (r == 2 && a != b)) ptr[a] = upd(ptr[a], ra.upd, mv[a]);
      if (r == 2) ptr[b] = upd(ptr[b], rb.upd, mv[b]);
      pc = jl ? jd : pc + fe;
      @(negedge REF_CLK);
      chk("data_a", ea.en ? da : {da.en, 17'h0}, ea);
      chk("data_b", eb.en ? db : {db.en, 17'h0}, eb);
      chk("prog", {pe, 1'b0, pa}, {fe, 1'b0, pc});
    end
    chk("triples", {17'h0, trip != 16'h0}, 18'h1);
    tally_and_finish();
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
